// file: hw/fstc_defines.svh
`ifndef FSTC_DEFINES_SVH
`define FSTC_DEFINES_SVH

// Clock and time base
`define FSTC_CLK_PERIOD_NS 50
`define FSTC_NS_PER_US     1000
`define FSTC_CYC_PER_US    (`FSTC_NS_PER_US / `FSTC_CLK_PERIOD_NS)
`define FSTC_CLK_HZ        20000000
`define FSTC_READOUT_CYCLES 100

// Trigger target selection
`define FSTC_SEL_ACQ       1'h0
`define FSTC_SEL_FRAME     1'h1

// Trigger origin encodings
`define FSTC_ORG_SOFTWARE  1'h0
`define FSTC_ORG_HW_INPUT_ONE     1'h1

// Reset values
`define FSTC_RST_TRIG_ON   1'h0
`define FSTC_RST_ORIGIN    `FSTC_ORG_HW_INPUT_ONE

// Shutter timing kinds
`define FSTC_SHUT_TIMED    1'h0
`define FSTC_SHUT_WIDTH    1'h1

// Capture run kinds
`define FSTC_RUN_SINGLE    1'h0
`define FSTC_RUN_CONTINUOUS 1'h1

// Edge polarity
`define FSTC_EDGE_RISING   1'h0
`define FSTC_EDGE_FALLING  1'h1

`endif

// file: hw/fstc_pkg.sv
`default_nettype none
package fstc_pkg;

  typedef enum logic [2:0] {
    FSTC_IDLE    = 3'h1,
    FSTC_EXPOSE  = 3'h2,
    FSTC_RECOVER = 3'h4
  } fstc_state_type;

endpackage
`default_nettype wire

// file: hw/fstc_frame_start.sv
`include "fstc_defines.svh"
`default_nettype none

// Summary of operation
// [RL1] Software source: exposure timed from duration setting
// [RL2] Line source: timed or trigger-width exposure
// [RL3] Host issues one fire per wanted frame
// [RL4] Accepted fire while waiting starts exposure
// [RL5] Accepting a start leaves waiting status
// [RL6] Return to waiting automatically when ready
// [RL7] Host keeps timed shutter for software fires
// [RL8] Software mode: no internal pacing added
// [RL9] Host avoids firing above maximum rate
// [RL10] Fires while not waiting are dropped
// [RL11] Pacing on, triggering off: paced internally
// [RL12] Pacing off: triggers alone set timing
// [RL13] Fire counts only with frame target selected
// [RL14] Enable/origin writes go to selected target
// [RL15] Origins: software command or input line one
// [RL16] Host brackets capture with begin/end commands
// [RL17] Triggering off: internal starts per run kind
// [RL18] Paced rate capped at maximum allowed rate
// [RL19] Edge polarity selects rising or falling
// [RL20] Reset selects input line one as origin
// [RL21] Fire made single pulse; line synchronised
// [RL22] Waiting status output for the host
module fstc_frame_start #(
  parameter int unsigned CLK_HZ         = `FSTC_CLK_HZ,
  parameter int unsigned READOUT_CYCLES = `FSTC_READOUT_CYCLES,
  parameter int unsigned DUR_W          = 16,
  parameter int unsigned FPS_W          = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             triggerTargetSelect,
  input  wire logic             externalStartEnableWr,
  input  wire logic             externalStartEnableData,
  input  wire logic             startOriginSelectWr,
  input  wire logic             startOriginSelectData,
  input  wire logic             edgePolaritySelect,
  input  wire logic             hostFireCommand,
  input  wire logic             shutterTimingKind,
  input  wire logic [DUR_W-1:0] shutterDurationUs,
  input  wire logic             internalPacingOn,
  input  wire logic [FPS_W-1:0] internalPacingFps,
  input  wire logic             captureRunKind,
  input  wire logic             captureBeginCommand,
  input  wire logic             captureEndCommand,
  input  wire logic             hwInputOne,
  output logic                  waitingForStart,
  output logic                  exposureActive,
  output logic                  perImageBegin,
  output logic                  triggerDropped,
  output logic                  frameTriggerOn,
  output logic                  frameOrigin,
  output logic                  acqTriggerOn,
  output logic                  acqOrigin
);

  localparam int unsigned CYC_PER_US = `FSTC_CYC_PER_US;
  localparam int unsigned US_W = $clog2(CYC_PER_US + 1);
  localparam int unsigned REC_W = $clog2(READOUT_CYCLES + 1);
  localparam int unsigned ACC_W = $clog2(CLK_HZ + (1 << FPS_W)) + 1;
  localparam logic [ACC_W-1:0] CLK_HZ_A = ACC_W'(CLK_HZ);
  localparam logic [REC_W-1:0] REC_LOAD = REC_W'(READOUT_CYCLES);
  localparam logic [US_W-1:0] US_LAST = US_W'(CYC_PER_US - 1);

  if (CYC_PER_US < 1 || READOUT_CYCLES < 1 || CLK_HZ < 1000000
      || DUR_W < 1 || FPS_W < 1)
  begin : g_check
    $error("fstc_frame_start: unsupported parameter values");
  end

  fstc_pkg::fstc_state_type state_reg;
  fstc_pkg::fstc_state_type state_next;

  logic [1:0]       trigOn_reg;
  logic [1:0]       origin_reg;
  logic             lineMeta_reg;
  logic             lineSync_reg;
  logic             linePrev_reg;
  logic             firePrev_reg;
  logic             firePulse;
  logic             lineEdge;
  logic             lineActive;
  logic             acqActive_reg;
  logic             acqActive_next;
  logic             swTrig;
  logic             hwTrig;
  logic             intTrig;
  logic             anyTrig;
  logic             accept;
  logic             widthMode;
  logic             widthExp_reg;
  logic [US_W-1:0]  usDiv_reg;
  logic             usTick;
  logic [DUR_W-1:0] expCount_reg;
  logic [REC_W-1:0] recCount_reg;
  logic [ACC_W-1:0] paceAcc_reg;
  logic             paceDue_reg;
  logic             paceRun;

  // Per-target enable and origin, written through the target select
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trigOn_reg <= {2{`FSTC_RST_TRIG_ON}};
      origin_reg <= {2{`FSTC_RST_ORIGIN}};               // [RL20]
    end
    else
    begin
      if (externalStartEnableWr)
        trigOn_reg[triggerTargetSelect] <= externalStartEnableData; // [RL14]
      if (startOriginSelectWr)
        origin_reg[triggerTargetSelect] <= startOriginSelectData; // [RL15]
    end
  end

  // Input line synchroniser and edge history
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lineMeta_reg <= 1'h0;
      lineSync_reg <= 1'h0;
      linePrev_reg <= 1'h0;
    end
    else
    begin
      lineMeta_reg <= hwInputOne;                        // [RL21]
      lineSync_reg <= lineMeta_reg;
      linePrev_reg <= lineSync_reg;
    end
  end

  // Fire command reduced to one pulse per assertion
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      firePrev_reg <= 1'h0;
    else
      firePrev_reg <= hostFireCommand;
  end

  assign firePulse = hostFireCommand & ~firePrev_reg;    // [RL21]

  assign lineActive = (edgePolaritySelect == `FSTC_EDGE_FALLING)
                      ? ~lineSync_reg : lineSync_reg;
  assign lineEdge = (edgePolaritySelect == `FSTC_EDGE_FALLING)
                    ? (linePrev_reg & ~lineSync_reg)
                    : (~linePrev_reg & lineSync_reg);    // [RL19]

  // Trigger qualification
  assign swTrig = firePulse
                  && (triggerTargetSelect == `FSTC_SEL_FRAME) // [RL13]
                  && trigOn_reg[`FSTC_SEL_FRAME]
                  && (origin_reg[`FSTC_SEL_FRAME] == `FSTC_ORG_SOFTWARE);
  assign hwTrig = lineEdge && trigOn_reg[`FSTC_SEL_FRAME]
                  && (origin_reg[`FSTC_SEL_FRAME] == `FSTC_ORG_HW_INPUT_ONE);
  // Internal starts; without pacing they run at the fastest ready rate
  assign intTrig = !trigOn_reg[`FSTC_SEL_FRAME]
                   && (!internalPacingOn || paceDue_reg); // [RL17] [RL12]
  assign anyTrig = swTrig || hwTrig || intTrig;
  assign accept = waitingForStart && anyTrig;            // [RL4]

  // Trigger-width exposure only when the line is the origin
  assign widthMode = (origin_reg[`FSTC_SEL_FRAME] == `FSTC_ORG_HW_INPUT_ONE)
                     && (shutterTimingKind == `FSTC_SHUT_WIDTH); // [RL2]

  // Capture run state
  always_comb
  begin
    acqActive_next = acqActive_reg;
    if (captureEndCommand)
      acqActive_next = 1'h0;
    else if (accept && captureRunKind == `FSTC_RUN_SINGLE)
      acqActive_next = 1'h0;                             // [RL17]
    if (captureBeginCommand)
      acqActive_next = 1'h1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      acqActive_reg <= 1'h0;
    else
      acqActive_reg <= acqActive_next;
  end

  // Microsecond enable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      usDiv_reg <= '0;
    else if (usDiv_reg == US_LAST)
      usDiv_reg <= '0;
    else
      usDiv_reg <= usDiv_reg + US_W'(1);
  end

  assign usTick = (usDiv_reg == US_LAST);

  // Internal pacing accumulator: wraps at CLK_HZ / fps cycles
  assign paceRun = internalPacingOn && !trigOn_reg[`FSTC_SEL_FRAME]
                   && acqActive_reg;                     // [RL11] [RL8]

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      paceAcc_reg <= '0;
      paceDue_reg <= 1'h0;
    end
    else if (!paceRun)
    begin
      paceAcc_reg <= '0;
      paceDue_reg <= captureBeginCommand && internalPacingOn;
    end
    else
    begin
      if (paceAcc_reg + ACC_W'(internalPacingFps) >= CLK_HZ_A)
      begin
        paceAcc_reg <= paceAcc_reg + ACC_W'(internalPacingFps) - CLK_HZ_A;
        paceDue_reg <= 1'h1;                             // [RL11]
      end
      else
      begin
        paceAcc_reg <= paceAcc_reg + ACC_W'(internalPacingFps);
        if (accept)
          paceDue_reg <= 1'h0;                           // [RL18]
      end
    end
  end

  // Frame sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      fstc_pkg::FSTC_IDLE:
        if (accept)
          state_next = fstc_pkg::FSTC_EXPOSE;             // [RL5]
      fstc_pkg::FSTC_EXPOSE:
        if (widthExp_reg ? !lineActive
                         : (usTick && expCount_reg == '0))
          state_next = fstc_pkg::FSTC_RECOVER;
      fstc_pkg::FSTC_RECOVER:
        if (recCount_reg == '0)
          state_next = fstc_pkg::FSTC_IDLE;               // [RL6]
      default:
        state_next = fstc_pkg::FSTC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= fstc_pkg::FSTC_IDLE;
    else
      state_reg <= state_next;
  end

  // Exposure timing
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      expCount_reg <= '0;
      widthExp_reg <= 1'h0;
    end
    else if (accept)
    begin
      expCount_reg <= shutterDurationUs;                  // [RL1]
      widthExp_reg <= widthMode && hwTrig;                // [RL2]
    end
    else if (state_reg == fstc_pkg::FSTC_EXPOSE && usTick
             && expCount_reg != '0)
      expCount_reg <= expCount_reg - DUR_W'(1);
  end

  // Readout recovery before the next start can be taken
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      recCount_reg <= '0;
    else if (state_reg != fstc_pkg::FSTC_RECOVER)
      recCount_reg <= REC_LOAD - REC_W'(1);
    else if (recCount_reg != '0)
      recCount_reg <= recCount_reg - REC_W'(1);
  end

  // Registered outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      waitingForStart <= 1'h0;
      exposureActive  <= 1'h0;
      perImageBegin   <= 1'h0;
      triggerDropped  <= 1'h0;
    end
    else
    begin
      waitingForStart <= acqActive_next
                         && state_next == fstc_pkg::FSTC_IDLE; // [RL22]
      exposureActive  <= state_next == fstc_pkg::FSTC_EXPOSE;
      perImageBegin   <= accept;
      triggerDropped  <= (swTrig || hwTrig) && !waitingForStart; // [RL10]
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frameTriggerOn <= `FSTC_RST_TRIG_ON;
      frameOrigin    <= `FSTC_RST_ORIGIN;
      acqTriggerOn   <= `FSTC_RST_TRIG_ON;
      acqOrigin      <= `FSTC_RST_ORIGIN;
    end
    else
    begin
      frameTriggerOn <= trigOn_reg[`FSTC_SEL_FRAME];
      frameOrigin    <= origin_reg[`FSTC_SEL_FRAME];
      acqTriggerOn   <= trigOn_reg[`FSTC_SEL_ACQ];
      acqOrigin      <= origin_reg[`FSTC_SEL_ACQ];
    end
  end

  a_accept_start: assert property (@(posedge clk) // [RL4]
    disable iff (!reset_n) accept |=> perImageBegin && exposureActive)
    else $error("accepted trigger did not start exposure");

  a_leave_waiting: assert property (@(posedge clk) // [RL5]
    disable iff (!reset_n) accept |=> !waitingForStart)
    else $error("waiting status kept after accepting a start");

  a_return_waiting: assert property (@(posedge clk) // [RL6]
    disable iff (!reset_n)
    (state_reg == fstc_pkg::FSTC_RECOVER && recCount_reg == '0
     && acqActive_next) |=> waitingForStart)
    else $error("waiting status not restored after recovery");

  a_drop_fire: assert property (@(posedge clk) // [RL10]
    disable iff (!reset_n)
    (swTrig && !waitingForStart) |=> !perImageBegin && triggerDropped)
    else $error("fire while busy was not dropped");

  a_fire_select: assert property (@(posedge clk) // [RL13]
    disable iff (!reset_n)
    (triggerTargetSelect == `FSTC_SEL_ACQ && trigOn_reg[`FSTC_SEL_FRAME]
     && origin_reg[`FSTC_SEL_FRAME] == `FSTC_ORG_SOFTWARE)
    |=> !perImageBegin)
    else $error("fire acted with acquisition target selected");

  a_timed_hold: assert property (@(posedge clk) // [RL1]
    disable iff (!reset_n)
    (exposureActive && !widthExp_reg && expCount_reg != '0)
    |=> exposureActive)
    else $error("timed exposure ended early");

  a_edge_detect: assert property (@(posedge clk) // [RL19]
    disable iff (!reset_n)
    (edgePolaritySelect == `FSTC_EDGE_RISING && $rose(lineSync_reg))
    |-> lineEdge)
    else $error("rising edge on line not detected");

  a_sync_delay: assert property (@(posedge clk) // [RL21]
    disable iff (!reset_n) lineSync_reg == $past(hwInputOne, 2))
    else $error("line synchroniser depth wrong");

  a_fire_pulse: assert property (@(posedge clk) // [RL21]
    disable iff (!reset_n) firePulse |=> !firePulse)
    else $error("fire pulse longer than one cycle");

  a_no_pace_sw: assert property (@(posedge clk) // [RL8]
    disable iff (!reset_n) trigOn_reg[`FSTC_SEL_FRAME] |=> paceAcc_reg == '0)
    else $error("internal pacing ran with triggering on");

  a_single_stop: assert property (@(posedge clk) // [RL17]
    disable iff (!reset_n)
    (accept && captureRunKind == `FSTC_RUN_SINGLE && !captureBeginCommand)
    |=> !acqActive_reg)
    else $error("single run did not end after one frame");

endmodule
`default_nettype wire

// file: testbench/fstc_partner_model.sv
`default_nettype none
// Host fire button and external line source, driven off the falling edge
module fstc_partner_model (
  input  wire logic clk,
  output logic      hostFire,
  output logic      lineLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  initial hostFire = 1'h0;
  initial lineLevel = 1'h0;
  // One fire for each wanted frame
  task automatic pulseFire();
    @(negedge clk) hostFire = 1'h1;
    @(negedge clk) hostFire = 1'h0;
  endtask
  task automatic setLine(input logic v);
    @(negedge clk) lineLevel = v;
  endtask
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        reset_n;
  logic        sel;
  logic        enWr;
  logic        enD;
  logic        orgWr;
  logic        orgD;
  logic        pol;
  logic        kind;
  logic        pace;
  logic        run;
  logic        beginCmd;
  logic        endCmd;
  logic [15:0] dur;
  logic [7:0]  fps;
  wire logic   fire;
  wire logic   line;
  wire logic   waitS;
  wire logic   expo;
  wire logic   img;
  wire logic   drop;
  wire logic   fOn;
  wire logic   fOrg;
  wire logic   aOn;
  wire logic   aOrg;
  int          badCount;
  int          nTests;
  int          imgCnt;
  int          dropCnt;
  int          n;
  int          s;
  int          d;

  fstc_frame_start #(.CLK_HZ(1000000), .READOUT_CYCLES(2)) dut_u (
    .clk(clk), .reset_n(reset_n), .triggerTargetSelect(sel),
    .externalStartEnableWr(enWr), .externalStartEnableData(enD),
    .startOriginSelectWr(orgWr), .startOriginSelectData(orgD),
    .edgePolaritySelect(pol), .hostFireCommand(fire),
    .shutterTimingKind(kind), .shutterDurationUs(dur),
    .internalPacingOn(pace), .internalPacingFps(fps),
    .captureRunKind(run), .captureBeginCommand(beginCmd),
    .captureEndCommand(endCmd), .hwInputOne(line),
    .waitingForStart(waitS), .exposureActive(expo),
    .perImageBegin(img), .triggerDropped(drop),
    .frameTriggerOn(fOn), .frameOrigin(fOrg),
    .acqTriggerOn(aOn), .acqOrigin(aOrg));

  fstc_partner_model p_u (.clk(clk), .hostFire(fire), .lineLevel(line));

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (img === 1'h1)
      imgCnt++;
    if (drop === 1'h1)
      dropCnt++;
  end

  task automatic printVerdict();
    $display("Checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic checkBit(input string nm, input logic e, input logic g);
    nTests++;
    if (g !== e)
    begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic checkCnt(input string nm, input int e, input int g);
    nTests++;
    if (g != e)
    begin
      badCount++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Settings write: origin when org is set, trigger enable otherwise
  task automatic wrSet(input logic tgt, input logic org, input logic v);
    sel = tgt;
    orgWr = org;
    enWr = !org;
    orgD = v;
    enD = v;
    @(negedge clk);
    orgWr = 1'h0;
    enWr = 1'h0;
    repeat (2) @(negedge clk);
  endtask

  task automatic cmd(input logic b);
    beginCmd = b;
    endCmd = !b;
    @(negedge clk);
    beginCmd = 1'h0;
    endCmd = 1'h0;
  endtask

  task automatic countImg(input int c, output int k);
    int s0;
    s0 = imgCnt;
    repeat (c) @(negedge clk);
    k = imgCnt - s0;
  endtask

  task automatic waitReady();
    for (int i = 0; i < 200 && waitS !== 1'h1; i++)
      @(negedge clk);
    checkBit("waiting", 1'h1, waitS);
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    badCount++;
    printVerdict();
  end

  initial
  begin
    {sel, enWr, enD, orgWr, orgD, pol, kind, pace} = '0;
    {run, beginCmd, endCmd} = '0;
    dur = 16'h0001;
    fps = 8'hC8;
    reset_n = 1'h0;
    repeat (12) @(negedge clk);
    reset_n = 1'h1;
    checkBit("waiting", 1'h0, waitS);
    checkBit("frameOrigin", 1'h1, fOrg);
    checkBit("acqOrigin", 1'h1, aOrg);
    wrSet(1'h0, 1'h0, 1'h1);
    checkBit("acqOn", 1'h1, aOn);
    checkBit("frameOn", 1'h0, fOn);
    wrSet(1'h1, 1'h0, 1'h1);
    wrSet(1'h1, 1'h1, 1'h0);
    checkBit("frameOn", 1'h1, fOn);
    checkBit("frameOrigin", 1'h0, fOrg);
    checkBit("acqOrigin", 1'h1, aOrg);
    wrSet(1'h0, 1'h1, 1'h0);
    checkBit("acqOrigin", 1'h0, aOrg);
    checkBit("frameOrigin", 1'h0, fOrg);
    run = 1'h1;
    cmd(1'h1);
    countImg(50, n);
    checkCnt("frames", 0, n);
    checkBit("waiting", 1'h1, waitS);
    sel = 1'h0;
    p_u.pulseFire();
    countImg(50, n);
    checkCnt("frames", 0, n);
    sel = 1'h1;
    s = imgCnt;
    d = dropCnt;
    p_u.pulseFire();
    repeat (3) @(negedge clk);
    checkCnt("frames", 1, imgCnt - s);
    checkBit("waiting", 1'h0, waitS);
    checkBit("exposing", 1'h1, expo);
    p_u.pulseFire();
    repeat (3) @(negedge clk);
    checkCnt("drops", 1, dropCnt - d);
    waitReady();
    checkBit("exposing", 1'h0, expo);
    checkCnt("frames", 1, imgCnt - s);
    wrSet(1'h1, 1'h1, 1'h1);
    // Rising then falling polarity, each with both edge directions
    for (int i = 0; i < 4; i++)
    begin
      pol = i[1];
      p_u.setLine(!i[0]);
      countImg(80, n);
      checkCnt("lineFrames", (!i[0]) != i[1] ? 1 : 0, n);
    end
    pol = 1'h0;
    kind = 1'h1;
    p_u.setLine(1'h1);
    repeat (150) @(negedge clk);
    checkBit("widthExposure", 1'h1, expo);
    p_u.setLine(1'h0);
    repeat (20) @(negedge clk);
    checkBit("widthExposure", 1'h0, expo);
    kind = 1'h0;
    waitReady();
    cmd(1'h0);
    repeat (3) @(negedge clk);
    checkBit("waiting", 1'h0, waitS);
    wrSet(1'h1, 1'h0, 1'h0);
    cmd(1'h1);
    countImg(500, n);
    checkBit("repeats", 1'h1, n >= 5);
    cmd(1'h0);
    repeat (100) @(negedge clk);
    run = 1'h0;
    cmd(1'h1);
    countImg(300, n);
    checkCnt("singleFrames", 1, n);
    run = 1'h1;
    pace = 1'h1;
    cmd(1'h1);
    countImg(12000, n);
    checkCnt("pacedFrames", 3, n);
    cmd(1'h0);
    printVerdict();
  end
endmodule
`default_nettype wire
